// >>> nvsq_regs.vh
// Constants for the soft-sequence host controller of an nvSRAM.
// Assumes inclusion by bare name from the controller files.
`ifndef NVSQ_REGS_VH
`define NVSQ_REGS_VH

// Sequence addresses, low 16 bits of the device address
`define NVSQ_SEQ_A1        16'h4E38
`define NVSQ_SEQ_A2        16'hB1C7
`define NVSQ_SEQ_A3        16'h83E0
`define NVSQ_SEQ_A4        16'h7C1F
`define NVSQ_SEQ_A5        16'h703F
`define NVSQ_CMD_RECALL    16'h4C63
`define NVSQ_CMD_STORE     16'h8FC0
`define NVSQ_CMD_SAVE_OFF  16'h8B45
`define NVSQ_CMD_SAVE_ON   16'h4B46

// Command codes on the user port
`define NVSQ_OP_RECALL     2'h0
`define NVSQ_OP_STORE      2'h1
`define NVSQ_OP_SAVE_OFF   2'h2
`define NVSQ_OP_SAVE_ON    2'h3

// Decoded address field used by the device
`define NVSQ_DEC_HI        14
`define NVSQ_DEC_LO        2

// Read strobe timing in cycles (phase lengths)
`define NVSQ_SETUP_CYC     8'h02
`define NVSQ_STROBE_CYC    8'h08
`define NVSQ_HOLD_CYC      8'h02

// Recall time in ns and derived cycle count at 8 ns period
`define NVSQ_RECALL_NS     200
`define NVSQ_CLK_NS        8
`define NVSQ_RECALL_CYC    ((`NVSQ_RECALL_NS + `NVSQ_CLK_NS - 1) / `NVSQ_CLK_NS)

`endif

// >>> nvsq_rd_cycle.v
// One asynchronous read cycle generator for the nvSRAM pins.
// Assumes the caller holds i_start for one cycle and keeps address stable.
`timescale 1ns/1ps
`default_nettype none
`include "nvsq_regs.vh"

module nvsq_rd_cycle #(
  parameter AW = 19,
  parameter DW = 16
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_start,
  input  wire          i_use_oe,
  input  wire [AW-1:0] i_addr,
  input  wire [DW-1:0] i_dq,
  output reg  [AW-1:0] o_addr,
  output reg           o_cs_n,
  output reg           o_oe_n,
  output reg  [DW-1:0] o_data,
  output reg           o_done
);

  localparam S_IDLE   = 2'h0;
  localparam S_SETUP  = 2'h1;
  localparam S_STROBE = 2'h2;
  localparam S_HOLD   = 2'h3;

  reg [1:0] state_r;
  reg [7:0] cnt_r;

  // Phase sequencer; strobe chosen by i_use_oe, the other held low
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= S_IDLE;
      cnt_r   <= 8'h00;
      o_addr  <= {AW{1'b0}};
      o_cs_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_data  <= {DW{1'b0}};
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (i_start) begin
            o_addr  <= i_addr;
            o_cs_n  <= i_use_oe ? 1'b0 : 1'b1;
            o_oe_n  <= i_use_oe ? 1'b1 : 1'b0;
            cnt_r   <= `NVSQ_SETUP_CYC;
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r == 8'h01) begin
            o_cs_n  <= 1'b0;
            o_oe_n  <= 1'b0;
            cnt_r   <= `NVSQ_STROBE_CYC;
            state_r <= S_STROBE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_STROBE: begin
          if (cnt_r == 8'h01) begin
            o_data  <= i_dq;
            o_cs_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            cnt_r   <= `NVSQ_HOLD_CYC;
            state_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_HOLD: begin
          if (cnt_r == 8'h01) begin
            o_done  <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> nvsq_host.v
// Host controller issuing six-read soft sequences to an nvSRAM.
// Assumes synchronous pin inputs and exclusive ownership of the memory bus.
`timescale 1ns/1ps
`default_nettype none
`include "nvsq_regs.vh"

module nvsq_host #(
  parameter AW = 19,
  parameter DW = 16
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_cmd_valid,
  input  wire [1:0]    i_cmd_op,
  input  wire          i_cmd_use_oe,
  input  wire          i_cmd_persist,
  input  wire          i_store_busy_n,
  input  wire [DW-1:0] i_dq,
  output wire          o_cmd_ready,
  output reg           o_cmd_done,
  output reg           o_save_enabled,
  output wire [AW-1:0] o_addr,
  output wire          o_chip_select_n,
  output wire          o_output_strobe_n,
  output wire          o_write_strobe_n,
  output wire          o_upper_byte_sel_n,
  output wire          o_lower_byte_sel_n,
  output wire [DW-1:0] o_dq,
  output wire          o_dq_oe,
  output wire [DW-1:0] o_last_data
);

  // Controller states
  localparam S_IDLE    = 3'h0;
  localparam S_ISSUE   = 3'h1;
  localparam S_WAIT    = 3'h2;
  localparam S_RECALL  = 3'h3;
  localparam S_BUSY    = 3'h4;
  localparam S_PERSIST = 3'h5;

  // Recall hold-off, whole clock cycles rounded up
  localparam integer RECALL_CYC = `NVSQ_RECALL_CYC;

  // Main state and position within the six reads
  reg [2:0]    state_r;
  reg [2:0]    step_r;

  // Command fields latched when the request is taken
  reg [1:0]    op_r;
  reg          use_oe_r;
  reg          persist_r;

  // Recall wait counter and read engine handshake
  reg [15:0]   wait_r;
  reg          start_r;
  wire         rd_done;

  // Pattern of the current step and the pin address
  reg [15:0]   step_pat;
  reg [AW-1:0] seq_addr;

  // Address for a step; upper lines zero, device ignores them
  function [15:0] nvsq_step_addr;
    input [2:0] step;
    input [1:0] op;
    begin
      case (step)
        3'h0: nvsq_step_addr = `NVSQ_SEQ_A1;
        3'h1: nvsq_step_addr = `NVSQ_SEQ_A2;
        3'h2: nvsq_step_addr = `NVSQ_SEQ_A3;
        3'h3: nvsq_step_addr = `NVSQ_SEQ_A4;
        3'h4: nvsq_step_addr = `NVSQ_SEQ_A5;
        default: begin
          case (op)
            `NVSQ_OP_RECALL:   nvsq_step_addr = `NVSQ_CMD_RECALL;
            `NVSQ_OP_STORE:    nvsq_step_addr = `NVSQ_CMD_STORE;
            `NVSQ_OP_SAVE_OFF: nvsq_step_addr = `NVSQ_CMD_SAVE_OFF;
            default:           nvsq_step_addr = `NVSQ_CMD_SAVE_ON;
          endcase
        end
      endcase
    end
  endfunction

  // Drive only decoded bits 14..2 of the pattern, rest zero
  always @* begin
    step_pat = nvsq_step_addr(step_r, op_r);
    seq_addr = {AW{1'b0}};
    seq_addr[`NVSQ_DEC_HI:`NVSQ_DEC_LO] =
      step_pat[`NVSQ_DEC_HI:`NVSQ_DEC_LO];
  end

  // Read cycle engine drives address and strobes
  nvsq_rd_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_rd (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_start  (start_r),
    .i_use_oe (use_oe_r),
    .i_addr   (seq_addr),
    .i_dq     (i_dq),
    .o_addr   (o_addr),
    .o_cs_n   (o_chip_select_n),
    .o_oe_n   (o_output_strobe_n),
    .o_data   (o_last_data),
    .o_done   (rd_done)
  );

  // Never writes during a sequence; data bus stays released
  assign o_write_strobe_n   = 1'b1;
  assign o_dq               = {DW{1'b0}};
  assign o_dq_oe            = 1'b0;

  // Both byte lanes enabled; sequence matching ignores them
  assign o_upper_byte_sel_n = 1'b0;
  assign o_lower_byte_sel_n = 1'b0;

  // Ready only when idle and the device is not busy
  assign o_cmd_ready        = (state_r == S_IDLE) && i_store_busy_n;

  // Sequence and completion state machine
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r        <= S_IDLE;
      step_r         <= 3'h0;
      op_r           <= 2'h0;
      use_oe_r       <= 1'b0;
      persist_r      <= 1'b0;
      wait_r         <= 16'h0000;
      start_r        <= 1'b0;
      o_cmd_done     <= 1'b0;
      o_save_enabled <= 1'b1;
    end else begin
      start_r    <= 1'b0;
      o_cmd_done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // Take a request only while ready
          if (i_cmd_valid && o_cmd_ready) begin
            op_r      <= i_cmd_op;
            use_oe_r  <= i_cmd_use_oe;
            persist_r <= i_cmd_persist;
            step_r    <= 3'h0;
            state_r   <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          // One start pulse per read
          start_r <= 1'b1;
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          // Count finished reads, then act on the last
          if (rd_done) begin
            if (step_r != 3'h5) begin
              step_r  <= step_r + 3'h1;
              state_r <= S_ISSUE;
            end else begin
              // Sixth read done: act on the command
              wait_r <= RECALL_CYC[15:0];
              case (op_r)
                `NVSQ_OP_RECALL: state_r <= S_RECALL;
                `NVSQ_OP_STORE:  state_r <= S_BUSY;
                `NVSQ_OP_SAVE_OFF: begin
                  o_save_enabled <= 1'b0;
                  state_r <= persist_r ? S_PERSIST : S_BUSY;
                end
                default: begin
                  o_save_enabled <= 1'b1;
                  state_r <= persist_r ? S_PERSIST : S_BUSY;
                end
              endcase
            end
          end
        end
        S_RECALL: begin
          // Hold off all access for the recall time
          if (wait_r <= 16'h0001) begin
            state_r <= S_BUSY;
          end
          wait_r <= wait_r - 16'h0001;
        end
        S_PERSIST: begin
          // Follow a save setting change with a store
          op_r    <= `NVSQ_OP_STORE;
          step_r  <= 3'h0;
          state_r <= S_ISSUE;
        end
        S_BUSY: begin
          // Wait out store busy; a refused store never pulls it low
          if (i_store_busy_n) begin
            o_cmd_done <= 1'b1;
            state_r    <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> nvsq_dev_model.sv
// Behavioural soft-sequence nvSRAM device seen by the host controller.
// Assumes strobes come from the bench clock domain; sampled per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "nvsq_regs.vh"
module nvsq_dev_model #(
  parameter STORE_CYC = 20
) (
  input  wire logic        i_clk,
  input  wire logic [18:0] i_addr,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_low_supply,
  output var  logic [15:0] o_dq,
  output var  logic        o_busy_n,
  output var  logic        o_save_en,
  output var  logic        o_nv_save,
  output var  int          o_stores,
  output var  int          o_recalls
);
  logic [2:0]  step;
  logic [7:0]  bcnt;
  logic [7:0]  rcnt;
  logic        rd_q;
  wire         rd = !i_cs_n && !i_oe_n && o_busy_n &&
                    rcnt == 8'h00;
  wire  [12:0] a  = i_addr[14:2];
  // Decoded field of a sequence address
  function automatic logic [12:0] k(input logic [15:0] x);
    return x[14:2];
  endfunction
  // Prefix address expected at each step
  function automatic logic [15:0] pre(input logic [2:0] s);
    case (s)
      3'h0: return `NVSQ_SEQ_A1;
      3'h1: return `NVSQ_SEQ_A2;
      3'h2: return `NVSQ_SEQ_A3;
      3'h3: return `NVSQ_SEQ_A4;
      default: return `NVSQ_SEQ_A5;
    endcase
  endfunction
  // Delivered state
  initial begin
    {step, bcnt, rcnt, rd_q, o_dq} = '0;
    {o_busy_n, o_save_en, o_nv_save} = 3'h7;
    o_stores = 0;
    o_recalls = 0;
  end
  // Sequence tracker, store timer and data bus
  always @(posedge i_clk) begin
    rd_q <= rd;
    o_dq <= rd ? (i_addr[15:0] ^ 16'h5A5A) : ~o_dq;
    if (bcnt != 8'h00) begin
      bcnt <= bcnt - 8'h01;
      o_busy_n <= (bcnt == 8'h01);
    end
    if (rcnt != 8'h00) rcnt <= rcnt - 8'h01;
    if (!i_we_n) begin
      step <= 3'h0;
    end else if (rd_q && !rd) begin
      if (step == 3'h5) begin
        step <= 3'h0;
        if (a == k(`NVSQ_CMD_RECALL)) begin
          o_recalls <= o_recalls + 1;
          // Array cleared then reloaded; reads refused meanwhile
          rcnt <= 8'(`NVSQ_RECALL_CYC);
        end
        if (a == k(`NVSQ_CMD_STORE) && !i_low_supply) begin
          o_stores <= o_stores + 1;
          o_nv_save <= o_save_en;
          o_busy_n <= 1'b0;
          bcnt <= 8'(STORE_CYC);
        end
        if (a == k(`NVSQ_CMD_SAVE_OFF)) o_save_en <= 1'b0;
        if (a == k(`NVSQ_CMD_SAVE_ON)) o_save_en <= 1'b1;
      end else if (a == k(pre(step))) step <= step + 3'h1;
      else step <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> nvsq_host_sva.sv
// Checker on the host controller pins.
// Assumes binding to nvsq_host; single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "nvsq_regs.vh"
module nvsq_host_sva #(
  parameter AW = 19,
  parameter DW = 16
) (
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  input wire logic          i_cmd_valid,
  input wire logic          i_store_busy_n,
  input wire logic          o_cmd_ready,
  input wire logic          o_cmd_done,
  input wire logic [AW-1:0] o_addr,
  input wire logic          o_chip_select_n,
  input wire logic          o_output_strobe_n,
  input wire logic          o_write_strobe_n,
  input wire logic          o_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire        rd = !o_chip_select_n && !o_output_strobe_n;
  wire [15:0] a  = o_addr[15:0];
  // Address matches a sequence value on its decoded bits
  function automatic logic h(input logic [15:0] x);
    return a == (x & 16'h7FFC);
  endfunction
  chk_we_high: assert property (o_write_strobe_n)
    else $error("write strobe asserted");
  chk_bus_quiet: assert property (!o_dq_oe)
    else $error("data bus driven");
  chk_addr_low: assert property (o_addr[1:0] == 2'h0)
    else $error("low address bits set");
  chk_addr_set: assert property (rd |->
    h(`NVSQ_SEQ_A1) || h(`NVSQ_SEQ_A2) ||
    h(`NVSQ_SEQ_A3) || h(`NVSQ_SEQ_A4) || h(`NVSQ_SEQ_A5) ||
    h(`NVSQ_CMD_RECALL) || h(`NVSQ_CMD_STORE) || h(`NVSQ_CMD_SAVE_OFF) ||
    h(`NVSQ_CMD_SAVE_ON)) else $error("read outside sequence set");
  chk_addr_stable: assert property (rd |=> !rd || $stable(o_addr))
    else $error("address moved during read");
  chk_read_len: assert property ($rose(rd) |-> rd [*8] ##1 !rd)
    else $error("read strobe length wrong");
  chk_ready_busy: assert property (!i_store_busy_n |->
    !o_cmd_ready && !rd) else $error("ready or read while device busy");
  chk_done_pulse: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("done longer than a cycle");
  chk_take_ready: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
    else $error("ready after request taken");
  cov_done: cover property (o_cmd_done);
  cov_busy: cover property (!i_store_busy_n);
  cov_read: cover property ($rose(rd));
endmodule
bind nvsq_host nvsq_host_sva #(.AW(AW), .DW(DW)) u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .i_store_busy_n(i_store_busy_n), .o_cmd_ready(o_cmd_ready),
  .o_cmd_done(o_cmd_done), .o_addr(o_addr),
  .o_chip_select_n(o_chip_select_n), .o_output_strobe_n(o_output_strobe_n),
  .o_write_strobe_n(o_write_strobe_n), .o_dq_oe(o_dq_oe));
`default_nettype wire

// >>> tb.sv
// Self-checking bench: host controller against the device model.
// Assumes nvsq_regs.vh and the model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "nvsq_regs.vh"
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op = 2'h0;
  logic        use_oe = 1'b0;
  logic        persist = 1'b0;
  logic        low_supply = 1'b0;
  wire         busy_n, ready, done, save_en, cs_n, oe_n, we_n, dq_oe;
  wire         ub_n, lb_n, m_save, m_nv;
  wire  [18:0] addr;
  wire  [15:0] dq, dq_out, last;
  int          m_st, m_rc, n_errors = 0, compares = 0;
  nvsq_host i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_use_oe(use_oe), .i_cmd_persist(persist),
    .i_store_busy_n(busy_n), .i_dq(dq), .o_cmd_ready(ready),
    .o_cmd_done(done), .o_save_enabled(save_en), .o_addr(addr),
    .o_chip_select_n(cs_n), .o_output_strobe_n(oe_n), .o_write_strobe_n(we_n),
    .o_upper_byte_sel_n(ub_n), .o_lower_byte_sel_n(lb_n), .o_dq(dq_out),
    .o_dq_oe(dq_oe), .o_last_data(last));
  nvsq_dev_model i_dev (.i_clk(i_clk), .i_addr(addr), .i_cs_n(cs_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_low_supply(low_supply), .o_dq(dq),
    .o_busy_n(busy_n),
    .o_save_en(m_save), .o_nv_save(m_nv), .o_stores(m_st), .o_recalls(m_rc));
  // Clock, 8 ns period
  always #4 i_clk = ~i_clk;
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One command: wait ready, pulse valid, wait done
  task automatic run_cmd(input logic [1:0] op, input logic oe, pst);
    int n = 0;
    while (ready !== 1'b1 && n < 500) begin @(negedge i_clk); n++; end
    @(posedge i_clk);
    cmd_op <= op;
    use_oe <= oe;
    persist <= pst;
    cmd_valid <= 1'b1;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge i_clk); n++; end while (done !== 1'b1 && n < 1000);
    chk("done", 1, done);
  endtask
  // Every op, timing alternating between the two strobes
  task automatic t_ops;
    logic [15:0] ca [4] = '{`NVSQ_CMD_RECALL, `NVSQ_CMD_STORE,
                            `NVSQ_CMD_SAVE_OFF, `NVSQ_CMD_SAVE_ON};
    int st, rc;
    for (int op = 0; op < 4; op++) begin
      st = m_st;
      rc = m_rc;
      run_cmd(op[1:0], op[0], 1'b0);
      chk("recalls", rc + (op == 0), m_rc);
      chk("stores", st + (op == 1), m_st);
      chk("dev save", op != 2, m_save);
      chk("save_en", op != 2, save_en);
      chk("data", (ca[op] & 16'h7FFC) ^ 16'h5A5A, last);
    end
  endtask
  // Save change followed by a store reaches the stored setting
  task automatic t_persist;
    run_cmd(2'h2, 1'b1, 1'b1);
    chk("nv save off", 0, m_nv);
    run_cmd(2'h3, 1'b0, 1'b1);
    chk("nv save on", 1, m_nv);
  endtask
  // Low supply: the device refuses a requested store
  task automatic t_low;
    int st;
    st = m_st;
    run_cmd(2'h2, 1'b0, 1'b0);
    @(posedge i_clk);
    low_supply <= 1'b1;
    run_cmd(2'h1, 1'b1, 1'b0);
    chk("low stores", st, m_st);
    chk("low nv", 1, m_nv);
    @(posedge i_clk);
    low_supply <= 1'b0;
  endtask
  // Ready is low when the device is first seen busy storing
  task automatic t_busy;
    int n = 0;
    fork
      run_cmd(2'h1, 1'b0, 1'b0);
      begin
        while (busy_n !== 1'b0 && n < 500) begin @(negedge i_clk); n++; end
        chk("busy seen", 0, busy_n);
        chk("ready", 0, ready);
      end
    join
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("save reset", 1, save_en);
    chk("strobes idle", 2'h3, {cs_n, oe_n});
    chk("bus quiet", {1'b1, 17'h00000}, {we_n, dq_oe, dq_out});
    chk("byte sels", 2'h0, {ub_n, lb_n});
    t_ops();
    t_persist();
    t_low();
    t_busy();
    tally_and_finish();
  end
endmodule
`default_nettype wire
